/* prc_defs.svh */
// timing figures and code mapping constants of the rail programmer core
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// ---------------------------------------------------------------------------
// clock and documented times
// ---------------------------------------------------------------------------
`define PRC_CLK_MHZ                200
`define PRC_SHUTDOWN_LOW_US        200
`define PRC_STARTUP_SHORT_WINDOW_MS 10
`define PRC_NEG_REG_MS             20
`define PRC_RUN_PERSIST_MS         3

// least times, whole cycles at the clock rate
`define PRC_SHUTDOWN_LOW_CYC  (`PRC_SHUTDOWN_LOW_US * `PRC_CLK_MHZ)
`define PRC_STARTUP_CYC       (`PRC_STARTUP_SHORT_WINDOW_MS * 1000 * `PRC_CLK_MHZ)
`define PRC_NEG_REG_CYC       (`PRC_NEG_REG_MS * 1000 * `PRC_CLK_MHZ)
`define PRC_RUN_PERSIST_CYC   (`PRC_RUN_PERSIST_MS * 1000 * `PRC_CLK_MHZ)

// ---------------------------------------------------------------------------
// negative rail code mapping, magnitudes in millivolts
// ---------------------------------------------------------------------------
`define PRC_CODE_MAX          5'h1f
`define PRC_DEFAULT_MV        13'h0fa0
`define PRC_FIRST_STEP_MV     13'h1130
`define PRC_STEP_MV           13'h0064

`endif

/* prc_pkg.sv */
// types shared by the rail programmer core
package prc_pkg;

    // -----------------------------------------------------------------------
    // control sequence states, one-hot
    // -----------------------------------------------------------------------
    typedef enum logic [5:0] {
        PRC_OFF     = 6'b00_0001,
        PRC_BOOST   = 6'b00_0010,
        PRC_INVERT  = 6'b00_0100,
        PRC_RUN     = 6'b00_1000,
        PRC_FAULT   = 6'b01_0000,
        PRC_THERMAL = 6'b10_0000
    } prc_state_t;

endpackage : prc_pkg

/* prc_core.sv */
// control core: enable line decode, rail code counting, start-up and fault latching
//
// Behaviour
// - line high enables device; negative rail starts at default code, minus four volts
// - line low disables device and inhibits both converters
// - pulses outside allowed widths need not be recognised
// - after enable, rising edges are counted and set the negative rail code
// - on enable boost starts at once with reduced soft-start current limit
// - inverting converter starts at default code ten milliseconds after enable
// - in operation, rail low or negative rail high beyond 3 ms flags fault
// - fault shuts down both converters and disconnects outputs
// - fault stays latched until supply cycle or line low then high
// - start-up fault if positive rail not regulated at ten milliseconds
// - start-up fault if negative rail above short threshold at ten milliseconds
// - start-up fault if negative rail not regulated at twenty milliseconds
// - over-temperature enters latched thermal shutdown, all functions off
// - start-up only while supply lockout clear and line high
// - start-up short window uses 10 ms timer, operating short 3 ms timer
`timescale 1ns/100ps
`include "prc_defs.svh"

module prc_core
    import prc_pkg::*;
#(
    parameter int unsigned SHUTDOWN_LOW_CYC = `PRC_SHUTDOWN_LOW_CYC,
    parameter int unsigned STARTUP_CYC      = `PRC_STARTUP_CYC,
    parameter int unsigned NEG_REG_CYC      = `PRC_NEG_REG_CYC,
    parameter int unsigned RUN_PERSIST_CYC  = `PRC_RUN_PERSIST_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ctrl,
    input  wire logic        i_supply_low_lockout,
    input  wire logic        i_overtemp_trip,
    input  wire logic        i_positive_rail_low,
    input  wire logic        i_positive_rail_in_reg,
    input  wire logic        i_negative_rail_high,
    input  wire logic        i_negative_rail_short,
    input  wire logic        i_negative_rail_in_reg,
    output logic             o_boost_en,
    output logic             o_boost_soft_start,
    output logic             o_inverter_en,
    output logic             o_output_connect,
    output logic [4:0]       o_negative_rail_code,
    output logic [12:0]      o_negative_rail_mv,
    output logic             o_fault_latched,
    output logic             o_thermal_shutdown
);

    // -----------------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------------
    localparam int NIN = 8;
    logic [NIN-1:0] sync1_reg;
    logic [NIN-1:0] sync2_reg;
    logic           ctrl_s, lock_s, otp_s, pos_low_s, pos_reg_s, neg_high_s, neg_short_s;
    logic           neg_reg_s;
    logic           ctrl_d_reg;
    logic           ctrl_rise;
    prc_state_t     state_reg, state_next;
    logic [31:0]    elapsed_reg;
    logic [31:0]    low_reg;
    logic [31:0]    persist_reg;
    logic [4:0]     count_reg;
    logic           off_hit;
    logic           enabled;

    // map an edge count onto the rail magnitude in millivolts
    function automatic logic [12:0] prc_mv(input logic [4:0] c);
        logic [12:0] m;
        m = `PRC_DEFAULT_MV;
        if (c != 5'h00)
            m = 13'(`PRC_FIRST_STEP_MV - 13'(c - 5'h01) * `PRC_STEP_MV);
        return m;
    endfunction : prc_mv

    // -----------------------------------------------------------------------
    // input synchronisers: every pin and comparator is asynchronous here
    // -----------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_ctrl, i_supply_low_lockout, i_overtemp_trip, i_positive_rail_low,
                          i_positive_rail_in_reg, i_negative_rail_high, i_negative_rail_short,
                          i_negative_rail_in_reg};
            sync2_reg <= sync1_reg;
        end
    end

    assign {ctrl_s, lock_s, otp_s, pos_low_s, pos_reg_s, neg_high_s, neg_short_s,
            neg_reg_s} = sync2_reg;

    // -----------------------------------------------------------------------
    // line edge and low-time detection
    // -----------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            ctrl_d_reg <= 1'b0;
        else
            ctrl_d_reg <= ctrl_s;
    end

    // no width filter
    // every clean edge counts; pulses outside the range are not guaranteed anyway
    assign ctrl_rise = ctrl_s && !ctrl_d_reg;

    // low time runs only while enabled or latched; short lows stay programming
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            low_reg <= '0;
        else if (ctrl_s || state_reg == PRC_OFF)
            low_reg <= '0;
        else
            low_reg <= low_reg + 32'h0000_0001;
    end

    // only the full low time disables
    assign off_hit = !ctrl_s && (low_reg == 32'(SHUTDOWN_LOW_CYC - 1));
    assign enabled = (state_reg == PRC_BOOST) || (state_reg == PRC_INVERT) ||
                     (state_reg == PRC_RUN);

    // -----------------------------------------------------------------------
    // sequence state machine
    // -----------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PRC_OFF: begin
                if (ctrl_s && !lock_s)
                    state_next = PRC_BOOST;
            end
            PRC_BOOST: begin
                if (elapsed_reg == 32'(STARTUP_CYC - 1))
                    state_next = (!pos_reg_s || neg_short_s) ? PRC_FAULT : PRC_INVERT;
            end
            PRC_INVERT: begin
                if (elapsed_reg == 32'(NEG_REG_CYC - 1))
                    state_next = neg_reg_s ? PRC_RUN : PRC_FAULT;
            end
            PRC_RUN: begin
                if ((pos_low_s || neg_high_s) && persist_reg == 32'(RUN_PERSIST_CYC - 1))
                    state_next = PRC_FAULT;
            end
            PRC_FAULT, PRC_THERMAL: begin
                state_next = state_reg;
            end
            default: state_next = PRC_OFF;
        endcase
        if (otp_s && state_reg != PRC_OFF)
            state_next = PRC_THERMAL;
        // disable on long low or lockout
        if (off_hit || lock_s)
            state_next = PRC_OFF;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            state_reg <= PRC_OFF;
        else
            state_reg <= state_next;
    end

    // one timer from enable covers 10 ms and 20 ms checkpoints
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            elapsed_reg <= '0;
        else if (state_reg == PRC_OFF)
            elapsed_reg <= '0;
        else if (state_reg == PRC_BOOST || state_reg == PRC_INVERT)
            elapsed_reg <= elapsed_reg + 32'h0000_0001;
    end

    // operating persistence timer, restarts when the condition clears
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            persist_reg <= '0;
        else if (state_reg == PRC_RUN && (pos_low_s || neg_high_s))
            persist_reg <= persist_reg + 32'h0000_0001;
        else
            persist_reg <= '0;
    end

    // -----------------------------------------------------------------------
    // rail code counting
    // -----------------------------------------------------------------------
    // count edges once enabled
    // enabling edge seen in off state, saturate at top
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            count_reg <= 5'h00;
        else if (state_reg == PRC_OFF || state_next == PRC_OFF)
            count_reg <= 5'h00;
        else if (enabled && ctrl_rise && count_reg != `PRC_CODE_MAX)
            count_reg <= count_reg + 5'h01;
    end

    // -----------------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------------
    // soft start while sequencing
    // inverter only after the first window
    // fault and thermal states drop everything
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_boost_en         <= 1'b0;
            o_boost_soft_start <= 1'b0;
            o_inverter_en      <= 1'b0;
            o_output_connect   <= 1'b0;
            o_fault_latched    <= 1'b0;
            o_thermal_shutdown <= 1'b0;
        end else begin
            o_boost_en         <= state_next inside {PRC_BOOST, PRC_INVERT, PRC_RUN};
            o_boost_soft_start <= state_next inside {PRC_BOOST, PRC_INVERT};
            o_inverter_en      <= state_next inside {PRC_INVERT, PRC_RUN};
            o_output_connect   <= state_next inside {PRC_BOOST, PRC_INVERT, PRC_RUN};
            o_fault_latched    <= state_next == PRC_FAULT;
            o_thermal_shutdown <= state_next == PRC_THERMAL;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_negative_rail_code <= 5'h00;
            o_negative_rail_mv   <= `PRC_DEFAULT_MV;
        end else begin
            o_negative_rail_code <= count_reg;
            o_negative_rail_mv   <= prc_mv(count_reg);
        end
    end

    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_off_quiet: assert property (state_reg == PRC_OFF ##1 state_reg == PRC_OFF
        |-> !o_boost_en && !o_inverter_en && !o_output_connect)
        else $error("converters active while disabled");
    a_enable_start: assert property (
        state_reg == PRC_OFF && ctrl_s && !lock_s |=> state_reg == PRC_BOOST
        ##0 o_boost_en && o_boost_soft_start && !o_inverter_en && o_negative_rail_mv == 13'h0fa0)
        else $error("enable did not start boost at default code");
    a_lockout_hold: assert property (
        state_reg == PRC_OFF && lock_s |=> state_reg == PRC_OFF)
        else $error("start-up under supply lockout");
    a_inv_delay: assert property ($rose(o_inverter_en) |->
        elapsed_reg == STARTUP_CYC)
        else $error("inverter start not at first checkpoint");
    a_count_step: assert property (
        enabled && ctrl_rise && count_reg != 5'h1f && !off_hit && !lock_s && !otp_s
        |=> count_reg == $past(count_reg) + 5'h01 ##1 o_negative_rail_code == $past(count_reg))
        else $error("edge not counted");
    a_count_sat: assert property (count_reg == 5'h1f && state_reg != PRC_OFF
        |=> count_reg == 5'h1f || state_reg == PRC_OFF)
        else $error("count left saturation");
    a_mv_map: assert property (##1 o_negative_rail_mv == prc_mv($past(count_reg)))
        else $error("rail magnitude mismatch");
    a_run_fault: assert property (
        state_reg == PRC_RUN && (pos_low_s || neg_high_s)
        && persist_reg == 32'(RUN_PERSIST_CYC - 1) && !off_hit && !lock_s && !otp_s
        |=> state_reg == PRC_FAULT && o_fault_latched && !o_boost_en)
        else $error("persistent rail fault missed");
    a_fault_latch: assert property (
        state_reg == PRC_FAULT && !off_hit && !lock_s && !otp_s |=> state_reg == PRC_FAULT)
        else $error("fault released early");
    a_thermal_trip: assert property (
        enabled && otp_s && !off_hit && !lock_s |=> state_reg == PRC_THERMAL && o_thermal_shutdown)
        else $error("thermal trip missed");
    a_neg_late: assert property (
        state_reg == PRC_INVERT && elapsed_reg == 32'(NEG_REG_CYC - 1) && !neg_reg_s
        && !off_hit && !lock_s && !otp_s |=> state_reg == PRC_FAULT)
        else $error("negative rail start-up fault missed");

    c_reach_run: cover property (state_reg == PRC_INVERT ##1 state_reg == PRC_RUN);
    c_fault:     cover property (state_reg == PRC_RUN ##1 state_reg == PRC_FAULT);
    c_thermal:   cover property ($rose(o_thermal_shutdown));
    c_sat:       cover property (count_reg == 5'h1f && ctrl_rise);

endmodule : prc_core

/* prc_host_model.sv */
// host side model: general purpose output that drives the enable/programming line
`timescale 1ns/100ps

module prc_host_model #(
    parameter int unsigned PULSE_CYC = 8,
    parameter int unsigned OFF_CYC   = 45
) (
    input  wire logic i_clk,
    output logic      o_ctrl
);
    // the line rests low, as its pull-down would hold it
    initial o_ctrl = 1'b0;

    task automatic enable();
        o_ctrl <= 1'b1;
        @(posedge i_clk);
    endtask : enable

    // widths inside limits
    // low phase kept well under the shutdown low time so it never disables
    task automatic pulses(input int n);
        for (int k = 0; k < n; k++) begin
            o_ctrl <= 1'b0;
            repeat (PULSE_CYC) @(posedge i_clk);
            o_ctrl <= 1'b1;
            repeat (PULSE_CYC) @(posedge i_clk);
        end
    endtask : pulses

    task automatic shutdown();
        o_ctrl <= 1'b0;
        repeat (OFF_CYC) @(posedge i_clk);
    endtask : shutdown
endmodule : prc_host_model

/* pulse_count_rail_programmer_tb_top.sv */
// self-checking bench of the rail programmer core driven by the host line model
`timescale 1ns/100ps
`define PRC_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module pulse_count_rail_programmer_tb_top;
    // -----------------------------------------------------------------------
    // shortened timing, matching the values handed to the core
    // -----------------------------------------------------------------------
    localparam int unsigned START_CYC  = 100;
    localparam int unsigned NEGREG_CYC = 200;
    localparam int unsigned PERS_CYC   = 30;
    localparam int unsigned CEIL_CYC   = 8000;
    localparam logic [4:0]  GOOD       = 5'h09;   // pos in reg, neg in reg

    logic        i_clk;
    logic        i_rst_n;
    logic        ctrl;
    logic        lockout, overtemp, pos_low, pos_in_reg, neg_high, neg_short, neg_in_reg;
    logic        boost_en, soft_start, inv_en, out_conn, fault, thermal;
    logic [4:0]  code;
    logic [12:0] mv;
    int          error_cnt, total_checks, cyc_cnt;

    prc_core #(.SHUTDOWN_LOW_CYC(40), .STARTUP_CYC(START_CYC), .NEG_REG_CYC(NEGREG_CYC),
               .RUN_PERSIST_CYC(PERS_CYC)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ctrl(ctrl), .i_supply_low_lockout(lockout),
        .i_overtemp_trip(overtemp), .i_positive_rail_low(pos_low),
        .i_positive_rail_in_reg(pos_in_reg), .i_negative_rail_high(neg_high),
        .i_negative_rail_short(neg_short), .i_negative_rail_in_reg(neg_in_reg),
        .o_boost_en(boost_en), .o_boost_soft_start(soft_start), .o_inverter_en(inv_en),
        .o_output_connect(out_conn), .o_negative_rail_code(code), .o_negative_rail_mv(mv),
        .o_fault_latched(fault), .o_thermal_shutdown(thermal));

    prc_host_model host (.i_clk(i_clk), .o_ctrl(ctrl));

    // -----------------------------------------------------------------------
    // clock, hang guard and verdict
    // -----------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // a stuck wait would otherwise run forever
    always @(posedge i_clk) begin
        cyc_cnt++;
        if (cyc_cnt == CEIL_CYC) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // -----------------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wait_cyc

    // rail monitor levels, order: pos low, pos in reg, neg high, neg short, neg in reg
    task automatic set_rails(input logic [4:0] v);
        {pos_low, pos_in_reg, neg_high, neg_short, neg_in_reg} <= v;
    endtask : set_rails

    // both converters and the output switch together
    task automatic chk_en(input logic b, input logic i);
        `PRC_CHK("boost_en", b, boost_en)
        `PRC_CHK("inverter_en", i, inv_en)
        `PRC_CHK("output_connect", b, out_conn)
    endtask : chk_en

    // magnitude in mV; counts past the table end stay on its last entry
    function automatic logic [12:0] exp_mv(input int n);
        int m;
        m = (n > 31) ? 31 : n;
        return (m == 0) ? 13'h0fa0 : 13'h1130 - 13'h0064 * 13'(m - 1);
    endfunction : exp_mv

    // -----------------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------------
    // clean enable walks boost, inverter and run phases
    task automatic t_startup();
        host.enable();
        wait_cyc(3);
        chk_en(1'b1, 1'b0);
        `PRC_CHK("soft_start", 1'b1, soft_start)
        `PRC_CHK("code", 5'h00, code)
        `PRC_CHK("mv", 13'h0fa0, mv)
        wait_cyc(START_CYC - 12);
        `PRC_CHK("inverter_early", 1'b0, inv_en)
        wait_cyc(20);
        `PRC_CHK("inverter_on", 1'b1, inv_en)
        wait_cyc(NEGREG_CYC - START_CYC);
        `PRC_CHK("soft_start_run", 1'b0, soft_start)
    endtask : t_startup

    // every count up to and past the last entry, short lows keep it running
    task automatic t_program();
        for (int n = 1; n <= 33; n++) begin
            host.pulses(1);
            `PRC_CHK("code", (n > 31) ? 5'h1f : 5'(n), code)
            `PRC_CHK("mv", exp_mv(n), mv)
        end
        chk_en(1'b1, 1'b1);
        host.shutdown();
        wait_cyc(4);
        chk_en(1'b0, 1'b0);
        `PRC_CHK("code_off", 5'h00, code)
    endtask : t_program

    // each start-up check fails on its own, then a line toggle restarts
    task automatic t_start_fault();
        logic [4:0] pat [3] = '{5'h01, 5'h0b, 5'h08};
        for (int k = 0; k < 3; k++) begin
            set_rails(pat[k]);
            host.enable();
            wait_cyc(NEGREG_CYC + 10);
            chk_en(1'b0, 1'b0);
            `PRC_CHK("start_fault", 1'b1, fault)
            set_rails(GOOD);
            wait_cyc(10);
            `PRC_CHK("fault_held", 1'b1, fault)
            host.shutdown();
            host.enable();
            wait_cyc(3);
            chk_en(1'b1, 1'b0);
            `PRC_CHK("fault_clr", 1'b0, fault)
            host.shutdown();
        end
    endtask : t_start_fault

    // short glitch is tolerated, a persistent one latches a fault
    task automatic t_run_fault();
        logic [4:0] pat [2] = '{5'h19, 5'h0d};
        for (int k = 0; k < 2; k++) begin
            host.enable();
            wait_cyc(NEGREG_CYC + 10);
            set_rails(pat[k]);
            wait_cyc(PERS_CYC - 10);
            set_rails(GOOD);
            wait_cyc(4);
            `PRC_CHK("glitch", 1'b0, fault)
            set_rails(pat[k]);
            wait_cyc(PERS_CYC + 5);
            chk_en(1'b0, 1'b0);
            `PRC_CHK("run_fault", 1'b1, fault)
            set_rails(GOOD);
            host.shutdown();
        end
    endtask : t_run_fault

    // over-temperature latches until the line is toggled
    task automatic t_thermal();
        host.enable();
        wait_cyc(NEGREG_CYC + 10);
        overtemp <= 1'b1;
        wait_cyc(4);
        `PRC_CHK("thermal", 1'b1, thermal)
        chk_en(1'b0, 1'b0);
        overtemp <= 1'b0;
        wait_cyc(10);
        `PRC_CHK("thermal_held", 1'b1, thermal)
        host.shutdown();
        host.enable();
        wait_cyc(3);
        `PRC_CHK("thermal_clr", 1'b0, thermal)
        chk_en(1'b1, 1'b0);
        host.shutdown();
    endtask : t_thermal

    // lockout blocks start-up and stops a running device
    task automatic t_lockout();
        lockout <= 1'b1;
        host.enable();
        wait_cyc(10);
        chk_en(1'b0, 1'b0);
        host.shutdown();
        lockout <= 1'b0;
        host.enable();
        wait_cyc(NEGREG_CYC + 10);
        lockout <= 1'b1;
        wait_cyc(4);
        chk_en(1'b0, 1'b0);
        lockout <= 1'b0;
        host.shutdown();
    endtask : t_lockout

    // a power-up reset in mid-run clears a latched fault; the line stays high throughout
    task automatic t_supply_cycle();
        host.enable();
        wait_cyc(NEGREG_CYC + 10);
        set_rails(5'h19);
        wait_cyc(PERS_CYC + 5);
        `PRC_CHK("fault_before_cycle", 1'b1, fault)
        set_rails(GOOD);
        i_rst_n <= 1'b0;
        wait_cyc(2);
        `PRC_CHK("fault_in_reset", 1'b0, fault)
        i_rst_n <= 1'b1;
        wait_cyc(4);
        `PRC_CHK("fault_after_cycle", 1'b0, fault)
        chk_en(1'b1, 1'b0);
        `PRC_CHK("mv_after_cycle", 13'h0fa0, mv)
        host.shutdown();
    endtask : t_supply_cycle

    // -----------------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------------
    initial begin
        i_rst_n  = 1'b0;
        lockout  = 1'b0;
        overtemp = 1'b0;
        {pos_low, pos_in_reg, neg_high, neg_short, neg_in_reg} = GOOD;
        wait_cyc(16);
        chk_en(1'b0, 1'b0);
        `PRC_CHK("mv_reset", 13'h0fa0, mv)
        i_rst_n <= 1'b1;
        wait_cyc(2);
        t_startup();
        t_program();
        t_start_fault();
        t_run_fault();
        t_thermal();
        t_lockout();
        t_supply_cycle();
        end_of_test();
    end
endmodule : pulse_count_rail_programmer_tb_top
